// *** rtl/tsr_regs.svh ***
// Register offsets, reset values, field masks and timing figures of the sensor bus slave.
`ifndef TSR_REGS_SVH
`define TSR_REGS_SVH
`define TSR_A_LOC_HI 8'h00
`define TSR_A_RSG_HI 8'h01
`define TSR_A_STAT1 8'h02
`define TSR_A_GCFG 8'h03
`define TSR_A_GCFG_ALT 8'h09
`define TSR_A_RATE 8'h04
`define TSR_A_RATE_ALT 8'h0a
`define TSR_A_ROS 8'h07
`define TSR_A_ROS_ALT 8'h0d
`define TSR_A_ONESHOT 8'h0f
`define TSR_A_RSG_LO 8'h10
`define TSR_A_OFS_HI 8'h11
`define TSR_A_OFS_LO 8'h12
`define TSR_A_RCRIT 8'h19
`define TSR_A_LLIM 8'h20
`define TSR_A_HYST 8'h21
`define TSR_A_LOC_LO 8'h30
`define TSR_A_RUS_HI 8'h31
`define TSR_A_RUS_LO 8'h32
`define TSR_A_STAT2 8'h33
`define TSR_A_DCFG 8'hbf
`define TSR_A_MAKER 8'hfe
`define TSR_A_REV 8'hff
`define TSR_RST_SEL 8'h00
`define TSR_RST_GCFG 8'h00
`define TSR_RST_RATE 2'h2
`define TSR_RST_ROS 8'h55
`define TSR_RST_OFS_HI 8'h00
`define TSR_RST_OFS_LO 8'h00
`define TSR_RST_RCRIT 8'h6e
`define TSR_RST_LLIM 7'h55
`define TSR_RST_HYST 5'h0a
`define TSR_RST_DCFG 8'h1f
`define TSR_MASK_GCFG 8'h5e
`define TSR_MASK_OFS_LO 8'he0
`define TSR_MASK_DCFG 8'h7e
`define TSR_ONES_DCFG 8'h01
`define TSR_MASK_LOC_LO 8'he0
`define TSR_MASK_REM_LO 8'hf8
`define TSR_BIT_STANDBY 6
`define TSR_BIT_READ 0
`define TSR_LAST_BIT 4'h7
`define TSR_BYTE_BITS 4'h8
`define TSR_IDX_ADDR 2'h0
`define TSR_IDX_CMD 2'h1
`define TSR_IDX_DATA 2'h2
`define TSR_TIMEOUT_MS 35
`define TSR_CORE_KHZ 40000
`endif

// *** rtl/tsr_pkg.sv ***
// Types shared by the sensor bus slave.
package tsr_pkg;
  typedef enum logic [2:0] {
    tsr_idle = 3'h0,
    tsr_rx = 3'h1,
    tsr_rx_hold = 3'h2,
    tsr_ack_out = 3'h3,
    tsr_tx = 3'h4,
    tsr_ack_in = 3'h5
  } tsr_state_t;
endpackage : tsr_pkg

// *** rtl/tsr_smbus_regs.sv ***
// Two-wire bus slave and register bank of the two-channel temperature sensor.
//
// Overview of operation
// - Every byte moves most significant bit first, in both directions.
// - After a read byte, acknowledge or not-acknowledge is accepted; not-acknowledge ends it.
// - Reading a temperature high byte freezes its matching low byte.
// - Reading the frozen low byte releases the freeze.
// - Each repeated high-byte read replaces the frozen low byte with the new one.
// - Bus logic returns to idle when neither line changes, with one of them low, for longer than 35 ms.
// - A start condition anywhere abandons the transfer; an address byte follows.
// - One-shot write in standby triggers exactly one conversion cycle.
// - One-shot data is discarded and the location reads zero.
// - Command byte of a write sets the 8-bit register selector.
// - One-shot acts only while the standby bit is 1.
// - Unsigned remote temperature reads at 0x31 high and 0x32 low.
// - Diode configuration at 0xbf is read-write and resets to 0x1f.
// - General configuration resets to 0x00 and answers at 0x03 and 0x09.
// - Two-bit conversion rate at 0x04 or 0x0a resets to 0x02.
// - First status at 0x02 is read-only busy and alarm bits.
// - Second status at 0x33 is read-only not-ready and diode-detect.
// - Seven-bit local shared limit at 0x20 resets to 0x55.
// - Maker identity at 0xfe and revision read fixed codes.
// - Selector starts at zero and keeps its value until rewritten.
`timescale 1ns/1ps
`include "tsr_regs.svh"

module tsr_smbus_regs
  import tsr_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h4c,
  // Identification values are arbitrary.
  parameter logic [7:0] MAKER_ID = 8'h5a,
  parameter logic [7:0] REVISION = 8'h3c,
  parameter int unsigned TIMEOUT_CYCLES = `TSR_TIMEOUT_MS * `TSR_CORE_KHZ
) (
  // Core clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Bus pins.
  input wire logic smb_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Conversion results and status.
  input wire logic [15:0] local_temp_word,
  input wire logic [15:0] remote_signed_word,
  input wire logic [15:0] remote_unsigned_word,
  input wire logic [7:0] status_primary_in,
  input wire logic [7:0] status_secondary_in,
  // Settings to the conversion logic.
  output logic [7:0] general_config,
  output logic [1:0] conversion_rate,
  output logic [7:0] remote_overtemp_limit,
  output logic [7:0] remote_offset_high,
  output logic [7:0] remote_offset_low,
  output logic [7:0] remote_critical_limit,
  output logic [6:0] local_shared_limit,
  output logic [4:0] common_hysteresis,
  output logic [7:0] diode_config,
  output logic single_conversion_start
);

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [7:0] HI_ADDR [3] = '{`TSR_A_LOC_HI, `TSR_A_RSG_HI, `TSR_A_RUS_HI};
  localparam logic [7:0] LO_ADDR [3] = '{`TSR_A_LOC_LO, `TSR_A_RSG_LO, `TSR_A_RUS_LO};

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: each rising bus clock samples the data line and toggles.
  // The toggle leaves reset only after two bus clock rises following release.
  logic lrst_s1, lrst_s2, link_bit, link_tog;

  always_ff @(posedge smb_clk) begin
    lrst_s1 <= srst;
    lrst_s2 <= lrst_s1;
    link_bit <= sda_in;
    if (lrst_s2) begin
      link_tog <= 1'b0;
    end else begin
      link_tog <= ~link_tog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core-side synchronisers and bus events.
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic tog_s1, tog_s2, tog_s3;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      {scl_s3, scl_s2, scl_s1} <= 3'h7;
      {sda_s3, sda_s2, sda_s1} <= 3'h7;
      {tog_s3, tog_s2, tog_s1} <= 3'h0;
    end else begin
      {scl_s3, scl_s2, scl_s1} <= {scl_s2, scl_s1, smb_clk};
      {sda_s3, sda_s2, sda_s1} <= {sda_s2, sda_s1, sda_in};
      {tog_s3, tog_s2, tog_s1} <= {tog_s2, tog_s1, link_tog};
    end
  end
  // The sampled bit is stable for a whole clock high time when the event is seen.
  wire bit_ev = tog_s2 ^ tog_s3;
  wire scl_fall = scl_s3 & ~scl_s2;
  wire start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  wire line_chg = (scl_s2 ^ scl_s3) | (sda_s2 ^ sda_s3);
  wire both_high = scl_s2 & sda_s2;

  ////////////////////////////////////////////////////////////////////////////
  // Stuck-line timeout.
  logic [TW-1:0] to_cnt;
  wire timeout = (to_cnt == TW'(TIMEOUT_CYCLES));
  always_ff @(posedge core_clk) begin
    if (srst || line_chg || both_high || timeout) begin
      to_cnt <= '0;
    end else begin
      to_cnt <= TW'(to_cnt + 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state machine.
  tsr_state_t state, next_state;
  logic [3:0] bitcnt, next_bitcnt;
  logic [1:0] byte_idx, next_idx;
  logic rd_mode, next_rd;
  logic [7:0] rx_shift, next_rx;
  logic [7:0] tx_shift, next_tx;
  logic [7:0] selector;
  logic next_oe, rx_commit, tx_load;
  logic [7:0] rd_data;

  wire addr_ok = (rx_shift[7:1] == SLAVE_ADDR);
  wire ack_ok = (byte_idx != `TSR_IDX_ADDR) || addr_ok;
  wire wr_sel = rx_commit && (byte_idx == `TSR_IDX_CMD);
  wire wr_reg = rx_commit && (byte_idx == `TSR_IDX_DATA);

  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_idx = byte_idx;
    next_rd = rd_mode;
    next_rx = rx_shift;
    next_tx = tx_shift;
    next_oe = sda_oe;
    rx_commit = 1'b0;
    tx_load = 1'b0;
    if (start) begin
      next_state = tsr_rx;
      next_bitcnt = 4'h0;
      next_idx = `TSR_IDX_ADDR;
      next_oe = 1'b0;
    end else if (stop || timeout) begin
      next_state = tsr_idle;
      next_oe = 1'b0;
    end else begin
      case (state)
        tsr_rx: begin
          if (bit_ev) begin
            next_rx = {rx_shift[6:0], link_bit};
            next_bitcnt = 4'(bitcnt + 4'h1);
            if (bitcnt == `TSR_LAST_BIT) begin
              next_state = tsr_rx_hold;
            end
          end
        end
        tsr_rx_hold: begin
          if (scl_fall) begin
            if (ack_ok) begin
              next_state = tsr_ack_out;
              next_oe = 1'b1;
              if (byte_idx == `TSR_IDX_ADDR) begin
                next_rd = rx_shift[`TSR_BIT_READ];
                tx_load = rx_shift[`TSR_BIT_READ];
              end else begin
                rx_commit = 1'b1;
              end
              if (byte_idx != `TSR_IDX_DATA) begin
                next_idx = 2'(byte_idx + 2'h1);
              end
            end else begin
              next_state = tsr_idle;
            end
          end
        end
        tsr_ack_out: begin
          if (scl_fall) begin
            next_bitcnt = 4'h0;
            if (rd_mode) begin
              next_state = tsr_tx;
              next_oe = ~tx_shift[7];
            end else begin
              next_state = tsr_rx;
              next_oe = 1'b0;
            end
          end
        end
        tsr_tx: begin
          if (bit_ev) begin
            next_tx = {tx_shift[6:0], 1'b0};
            next_bitcnt = 4'(bitcnt + 4'h1);
          end else if (scl_fall) begin
            if (bitcnt == `TSR_BYTE_BITS) begin
              next_state = tsr_ack_in;
              next_oe = 1'b0;
            end else begin
              next_oe = ~tx_shift[7];
            end
          end
        end
        tsr_ack_in: begin
          if (bit_ev) begin
            if (link_bit) begin
              next_state = tsr_idle;
            end else begin
              next_state = tsr_tx;
              next_bitcnt = 4'h0;
              tx_load = 1'b1;
            end
          end
        end
        default: begin
          next_state = tsr_idle;
        end
      endcase
    end
    if (tx_load) begin
      next_tx = rd_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= tsr_idle;
      bitcnt <= 4'h0;
      byte_idx <= `TSR_IDX_ADDR;
      rd_mode <= 1'b0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      byte_idx <= next_idx;
      rd_mode <= next_rd;
      rx_shift <= next_rx;
      tx_shift <= next_tx;
      sda_oe <= next_oe;
      sda_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-byte freeze for the three temperature pairs.
  logic [7:0] live_lo [3];
  logic [7:0] frozen_lo [3];
  logic [7:0] lo_view [3];
  logic [2:0] locked;

  assign live_lo[0] = local_temp_word[7:0] & `TSR_MASK_LOC_LO;
  assign live_lo[1] = remote_signed_word[7:0] & `TSR_MASK_REM_LO;
  assign live_lo[2] = remote_unsigned_word[7:0] & `TSR_MASK_REM_LO;

  for (genvar i = 0; i < 3; i++) begin : g_pair
    assign lo_view[i] = locked[i] ? frozen_lo[i] : live_lo[i];
    always_ff @(posedge core_clk) begin
      if (srst) begin
        locked[i] <= 1'b0;
        frozen_lo[i] <= 8'h00;
      end else if (tx_load && (selector == HI_ADDR[i])) begin
        locked[i] <= 1'b1;
        frozen_lo[i] <= live_lo[i];
      end else if (tx_load && (selector == LO_ADDR[i])) begin
        locked[i] <= 1'b0;
      end
    end
    lock_set_a: assert property (@(posedge core_clk) disable iff (srst)
      tx_load && selector == HI_ADDR[i] |=> locked[i] && frozen_lo[i] == $past(live_lo[i]))
      else $error("high-byte read did not freeze low byte");
    unlock_a: assert property (@(posedge core_clk) disable iff (srst)
      tx_load && selector == LO_ADDR[i] |=> !locked[i] ##1 (lo_view[i] == live_lo[i]))
      else $error("low-byte read did not release freeze");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  always_ff @(posedge core_clk) begin
    if (srst) begin
      selector <= `TSR_RST_SEL;
      general_config <= `TSR_RST_GCFG;
      conversion_rate <= `TSR_RST_RATE;
      remote_overtemp_limit <= `TSR_RST_ROS;
      remote_offset_high <= `TSR_RST_OFS_HI;
      remote_offset_low <= `TSR_RST_OFS_LO;
      remote_critical_limit <= `TSR_RST_RCRIT;
      local_shared_limit <= `TSR_RST_LLIM;
      common_hysteresis <= `TSR_RST_HYST;
      diode_config <= `TSR_RST_DCFG;
      single_conversion_start <= 1'b0;
    end else begin
      if (wr_sel) begin
        selector <= rx_shift;
      end
      if (wr_reg) begin
        case (selector)
          `TSR_A_GCFG, `TSR_A_GCFG_ALT: general_config <= rx_shift & `TSR_MASK_GCFG;
          `TSR_A_RATE, `TSR_A_RATE_ALT: conversion_rate <= rx_shift[1:0];
          `TSR_A_ROS, `TSR_A_ROS_ALT: remote_overtemp_limit <= rx_shift;
          `TSR_A_OFS_HI: remote_offset_high <= rx_shift;
          `TSR_A_OFS_LO: remote_offset_low <= rx_shift & `TSR_MASK_OFS_LO;
          `TSR_A_RCRIT: remote_critical_limit <= rx_shift;
          `TSR_A_LLIM: local_shared_limit <= rx_shift[6:0];
          `TSR_A_HYST: common_hysteresis <= rx_shift[4:0];
          `TSR_A_DCFG: diode_config <= (rx_shift & `TSR_MASK_DCFG) | `TSR_ONES_DCFG;
          default: begin
          end
        endcase
      end
      single_conversion_start <= wr_reg && (selector == `TSR_A_ONESHOT)
        && general_config[`TSR_BIT_STANDBY];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read selection.
  always_comb begin
    case (selector)
      `TSR_A_LOC_HI: rd_data = local_temp_word[15:8];
      `TSR_A_RSG_HI: rd_data = remote_signed_word[15:8];
      `TSR_A_RUS_HI: rd_data = remote_unsigned_word[15:8];
      `TSR_A_LOC_LO: rd_data = lo_view[0];
      `TSR_A_RSG_LO: rd_data = lo_view[1];
      `TSR_A_RUS_LO: rd_data = lo_view[2];
      `TSR_A_STAT1: rd_data = status_primary_in;
      `TSR_A_STAT2: rd_data = status_secondary_in;
      `TSR_A_GCFG, `TSR_A_GCFG_ALT: rd_data = general_config;
      `TSR_A_RATE, `TSR_A_RATE_ALT: rd_data = {6'h00, conversion_rate};
      `TSR_A_ROS, `TSR_A_ROS_ALT: rd_data = remote_overtemp_limit;
      `TSR_A_OFS_HI: rd_data = remote_offset_high;
      `TSR_A_OFS_LO: rd_data = remote_offset_low;
      `TSR_A_RCRIT: rd_data = remote_critical_limit;
      `TSR_A_LLIM: rd_data = {1'b0, local_shared_limit};
      `TSR_A_HYST: rd_data = {3'h0, common_hysteresis};
      `TSR_A_DCFG: rd_data = diode_config;
      `TSR_A_ONESHOT: rd_data = 8'h00;
      `TSR_A_MAKER: rd_data = MAKER_ID;
      `TSR_A_REV: rd_data = REVISION;
      default: rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_tx_shift;
    state == tsr_tx && bit_ev && !start && !stop && !timeout;
  endsequence
  sequence s_nack_seen;
    state == tsr_ack_in && bit_ev && link_bit && !start && !stop && !timeout;
  endsequence

  tx_msb_a: assert property (s_tx_shift |=>
    tx_shift == {$past(tx_shift[6:0]), 1'b0})
    else $error("transmit byte not shifted msb first");
  rx_msb_a: assert property (state == tsr_rx && bit_ev && !start && !stop && !timeout |=>
    rx_shift == {$past(rx_shift[6:0]), $past(link_bit)})
    else $error("receive byte not shifted msb first");
  nack_end_a: assert property (s_nack_seen |=> state == tsr_idle && !sda_oe
    ##1 (!sda_oe || start))
    else $error("not-acknowledge did not end the read");
  timeout_idle_a: assert property (timeout |=> state == tsr_idle && !sda_oe)
    else $error("timeout did not return to idle");
  start_abort_a: assert property (start |=>
    state == tsr_rx && bitcnt == 4'h0 && byte_idx == `TSR_IDX_ADDR && !sda_oe)
    else $error("start did not restart address phase");
  oneshot_once_a: assert property (single_conversion_start |->
    $past(wr_reg) && $past(general_config[`TSR_BIT_STANDBY])
    ##1 !single_conversion_start)
    else $error("one-shot trigger wrong");
  sel_write_a: assert property (wr_sel |=> selector == $past(rx_shift))
    else $error("command byte not latched");
  alias_cfg_a: assert property (wr_reg && selector == `TSR_A_GCFG_ALT |=>
    general_config == ($past(rx_shift) & `TSR_MASK_GCFG))
    else $error("alias write missed storage");
  oneshot_zero_a: assert property (selector == `TSR_A_ONESHOT |-> rd_data == 8'h00)
    else $error("one-shot location read nonzero");
  ro_keep_a: assert property (wr_reg && selector == `TSR_A_STAT1 |=>
    $stable(general_config) && $stable(diode_config) && $stable(conversion_rate))
    else $error("read-only write changed storage");

endmodule : tsr_smbus_regs

// *** tb/tsr_host_model.sv ***
// Behavioural bus master that drives the sensor's two-wire bus from the far side.
`timescale 1ns/1ps

module tsr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h4c
) (
  // Bus wires.
  output logic scl,
  output logic sda_pull,
  input wire logic sda_wire
);
  localparam realtime HALF = 62.5;
  int nack_seen = 0;
  int slow = 0;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) begin
      #HALF scl = 1'b0;
      #HALF scl = 1'b1;
    end
  endtask : tick

  task automatic bit_out(input logic b);
    #20 sda_pull = ~b;
    #(3 * HALF - 20 + slow) scl = 1'b1;
    #HALF scl = 1'b0;
  endtask : bit_out

  task automatic bit_in(output logic b);
    #20 sda_pull = 1'b0;
    #(3 * HALF - 20 + slow) scl = 1'b1;
    b = sda_wire;
    #HALF scl = 1'b0;
  endtask : bit_in

  task automatic start_c();
    #20 sda_pull = 1'b0;
    #(2 * HALF) scl = 1'b1;
    #(2 * HALF) sda_pull = 1'b1;
    #(2 * HALF) scl = 1'b0;
  endtask : start_c

  task automatic stop_c();
    #20 sda_pull = 1'b1;
    #(2 * HALF) scl = 1'b1;
    #(2 * HALF) sda_pull = 1'b0;
    #(2 * HALF);
  endtask : stop_c

  //////////////////////////////////////////////////////////////////////////////
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      bit_out(b[i]);
    end
  endtask : send_bits

  task automatic send_byte(input logic [7:0] b);
    logic a;
    send_bits(b, 8);
    bit_in(a);
    if (a !== 1'b0) begin
      nack_seen++;
    end
  endtask : send_byte

  task automatic recv_byte(output logic [7:0] b, input logic last);
    for (int i = 7; i >= 0; i--) begin
      bit_in(b[i]);
    end
    bit_out(last);
  endtask : recv_byte

  task automatic write_reg(input logic [7:0] sel, input logic [7:0] data);
    start_c();
    send_byte({DEV_ADDR, 1'b0});
    send_byte(sel);
    send_byte(data);
    stop_c();
  endtask : write_reg

  task automatic read_reg(input logic [7:0] sel, output logic [7:0] data);
    start_c();
    send_byte({DEV_ADDR, 1'b0});
    send_byte(sel);
    start_c();
    send_byte({DEV_ADDR, 1'b1});
    recv_byte(data, 1'b1);
    stop_c();
  endtask : read_reg

  task automatic read_cur(output logic [7:0] b0, output logic [7:0] b1);
    start_c();
    send_byte({DEV_ADDR, 1'b1});
    recv_byte(b0, 1'b0);
    recv_byte(b1, 1'b1);
    stop_c();
  endtask : read_cur

  // Clock stays low past the timeout, then is let go with data released.
  task automatic hold_low(input int ns);
    #20 sda_pull = 1'b0;
    #(ns) scl = 1'b1;
    #(2 * HALF);
  endtask : hold_low
endmodule : tsr_host_model

// *** tb/test_smbus_temp_sensor_regs.sv ***
// Self-checking testbench of the sensor bus slave and its register bank.
`timescale 1ns/1ps

module test_smbus_temp_sensor_regs;
  // Identification values are arbitrary.
  localparam logic [7:0] MAKER = 8'h5a;
  localparam logic [7:0] REV = 8'hc3;
  typedef struct packed {
    logic [7:0] wsel;
    logic [7:0] rsel;
    logic [7:0] rst;
    logic [7:0] exp;
  } tsr_row_t;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] local_temp_word = 16'h19e0;
  logic [15:0] remote_signed_word = 16'he7f8;
  logic [15:0] remote_unsigned_word = 16'h8c58;
  logic [7:0] status_primary_in = 8'h13;
  logic [7:0] status_secondary_in = 8'h02;
  logic smb_clk, sda_pull, sda_in, sda_out, sda_oe, single_conversion_start;
  logic [7:0] general_config, remote_overtemp_limit, remote_offset_high, remote_offset_low;
  logic [7:0] remote_critical_limit, diode_config, rd, b0, b1;
  logic [6:0] local_shared_limit;
  logic [4:0] common_hysteresis;
  logic [1:0] conversion_rate;
  int errors = 0;
  int n_compared = 0;
  int pulses = 0;
  tsr_row_t rows [20] = '{
    '{8'h09, 8'h03, 8'h00, 8'h14}, '{8'h0a, 8'h04, 8'h02, 8'h01},
    '{8'h0d, 8'h07, 8'h55, 8'h35}, '{8'h11, 8'h11, 8'h00, 8'h35},
    '{8'h12, 8'h12, 8'h00, 8'h20}, '{8'h19, 8'h19, 8'h6e, 8'h35},
    '{8'h20, 8'h20, 8'h55, 8'h35}, '{8'h21, 8'h21, 8'h0a, 8'h15},
    '{8'hbf, 8'hbf, 8'h1f, 8'h35}, '{8'h02, 8'h02, 8'h13, 8'h13},
    '{8'h33, 8'h33, 8'h02, 8'h02}, '{8'hfe, 8'hfe, MAKER, MAKER},
    '{8'hff, 8'hff, REV, REV}, '{8'h0f, 8'h0f, 8'h00, 8'h00},
    '{8'h31, 8'h31, 8'h8c, 8'h8c}, '{8'h01, 8'h01, 8'he7, 8'he7},
    '{8'h00, 8'h00, 8'h19, 8'h19}, '{8'h40, 8'h40, 8'h00, 8'h00},
    '{8'h30, 8'h30, 8'he0, 8'he0}, '{8'h10, 8'h10, 8'hf8, 8'hf8}
  };

  // The data wire is pulled up and low whenever either party pulls it.
  assign sda_in = ~(sda_oe | sda_pull);

  //////////////////////////////////////////////////////////////////////////////
  tsr_smbus_regs #(.MAKER_ID(MAKER), .REVISION(REV), .TIMEOUT_CYCLES(200)) DUT (
    .core_clk(core_clk), .srst(srst), .smb_clk(smb_clk), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .local_temp_word(local_temp_word),
    .remote_signed_word(remote_signed_word), .remote_unsigned_word(remote_unsigned_word),
    .status_primary_in(status_primary_in), .status_secondary_in(status_secondary_in),
    .general_config(general_config), .conversion_rate(conversion_rate),
    .remote_overtemp_limit(remote_overtemp_limit), .remote_offset_high(remote_offset_high),
    .remote_offset_low(remote_offset_low), .remote_critical_limit(remote_critical_limit),
    .local_shared_limit(local_shared_limit), .common_hysteresis(common_hysteresis),
    .diode_config(diode_config), .single_conversion_start(single_conversion_start)
  );

  tsr_host_model host (.scl(smb_clk), .sda_pull(sda_pull), .sda_wire(sda_in));

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (single_conversion_start === 1'b1) begin
      pulses++;
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic set_unsigned(input logic [15:0] w);
    @(posedge core_clk);
    #2 remote_unsigned_word = w;
  endtask : set_unsigned

  initial begin
    repeat (95000) @(posedge core_clk);
    errors++;
    final_report();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    // The link synchroniser needs bus clock edges while reset is held.
    fork
      host.tick(6);
    join_none
    repeat (32) @(posedge core_clk);
    #2 srst = 1'b0;
    // The link reset pipeline only clears on bus clock rises after release.
    host.tick(3);
    repeat (8) @(posedge core_clk);
    host.read_cur(b0, b1);
    check("first byte", b0, 8'h19);
    check("second byte", b1, 8'h19);
    foreach (rows[i]) begin
      host.read_reg(rows[i].rsel, rd);
      check($sformatf("reset of %h", rows[i].rsel), rd, rows[i].rst);
      host.write_reg(rows[i].wsel, 8'h35);
      host.read_reg(rows[i].rsel, rd);
      check($sformatf("read of %h", rows[i].rsel), rd, rows[i].exp);
    end
    check("config port", general_config, 8'h14);
    check("rate port", {6'h00, conversion_rate}, 8'h01);
    check("limit port", {1'b0, local_shared_limit}, 8'h35);
    check("diode port", diode_config, 8'h35);
    host.slow = 500;
    set_unsigned(16'h3158);
    host.read_reg(8'h31, rd);
    check("high byte", rd, 8'h31);
    set_unsigned(16'h42a0);
    host.read_reg(8'h32, rd);
    check("frozen low", rd, 8'h58);
    host.read_reg(8'h32, rd);
    check("released low", rd, 8'ha0);
    host.read_reg(8'h31, rd);
    set_unsigned(16'h5388);
    host.read_reg(8'h31, rd);
    check("second high", rd, 8'h53);
    set_unsigned(16'h6410);
    host.read_reg(8'h32, rd);
    check("refrozen low", rd, 8'h88);
    host.slow = 0;
    check("pulses in run", pulses[7:0], 8'h00);
    host.write_reg(8'h03, 8'h40);
    host.write_reg(8'h0f, 8'h5a);
    repeat (6) @(posedge core_clk);
    check("one pulse", pulses[7:0], 8'h01);
    host.read_reg(8'h0f, rd);
    check("trigger read", rd, 8'h00);
    check("still one pulse", pulses[7:0], 8'h01);
    host.start_c();
    host.send_byte({7'h4d, 1'b0});
    host.stop_c();
    host.start_c();
    host.send_byte({7'h4c, 1'b0});
    host.send_bits(8'h21, 4);
    host.write_reg(8'h21, 8'h07);
    host.read_reg(8'h21, rd);
    check("after restart", rd, 8'h07);
    check("hysteresis port", {3'h0, common_hysteresis}, 8'h07);
    host.start_c();
    host.send_byte({7'h4c, 1'b0});
    host.send_byte(8'h02);
    host.start_c();
    host.send_byte({7'h4c, 1'b1});
    #150;
    check("data drive", {7'h00, sda_oe}, 8'h01);
    host.hold_low(6250);
    check("released data", {7'h00, sda_oe}, 8'h00);
    host.read_reg(8'h33, rd);
    check("after timeout", rd, 8'h02);
    check("data out level", {7'h00, sda_out}, 8'h00);
    check("refused bytes", host.nack_seen[7:0], 8'h01);
    final_report();
  end
endmodule : test_smbus_temp_sensor_regs
